// File: verilog/banked_dmem.sv
`default_nettype none
module banked_dmem
  import dmem_pkg::*;
#(
  parameter int PC_WIDTH = 12,
  parameter int GP_SIZE = GP_TOTAL_SIZE
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic WDT_SLEEP_RESET,
  input wire logic REQ_VALID,
  input wire logic [2:0] REQ_OP,
  input wire logic [7:0] REQ_ADDR,
  input wire logic [7:0] REQ_WDATA,
  input wire logic [2:0] REQ_BIT,
  input wire logic [7:0] ALU_RESULT,
  input wire logic [PC_WIDTH-1:0] PC_IN,
  input wire logic [7:0] PERIPH_RDATA,
  input wire logic PERIPH_HIT,
  input wire logic PERIPH_READ_ONLY,
  output logic RESP_VALID,
  output logic [7:0] RESP_RDATA,
  output logic [7:0] ACC_OUT,
  output logic [7:0] POINTER_ZERO_OUT,
  output logic [7:0] POINTER_ONE_OUT,
  output logic BANK_SELECT_BIT,
  output logic JUMP_VALID,
  output logic [PC_WIDTH-1:0] JUMP_TARGET,
  output logic DUMMY_CYCLE,
  output logic PERIPH_WE,
  output logic [7:0] PERIPH_ADDR,
  output logic PERIPH_BANK,
  output logic [7:0] PERIPH_WDATA
);

  initial begin
    if (PC_WIDTH < 9 || PC_WIDTH > 16) $error("PC_WIDTH out of range");
    if (GP_SIZE != GP_TOTAL_SIZE) $error("GP_SIZE must match the map");
  end

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_DUMMY = 2'b10
  } flow_t;

  localparam int GP_IDX_W = $clog2(GP_SIZE);

  logic [7:0] gp_mem_q [GP_SIZE];
  logic [7:0] acc_q;
  logic [7:0] ptr0_q;
  logic [7:0] ptr1_q;
  logic bank_q;
  flow_t flow_q;
  logic resp_valid_q;
  logic [7:0] resp_rdata_q;
  logic jump_valid_q;
  logic [PC_WIDTH-1:0] jump_target_q;
  logic periph_we_q;
  logic [7:0] periph_addr_q;
  logic periph_bank_q;
  logic [7:0] periph_wdata_q;

  // Effective access after indirect redirection
  logic eff_indirect;
  logic eff_bank;
  logic [7:0] eff_addr;
  logic eff_null;
  logic gp_hit;
  logic [GP_IDX_W-1:0] gp_idx;
  logic sp_unused;
  logic [7:0] rd_value;
  logic [7:0] wr_value;
  logic do_write;
  logic accept;

  function automatic logic is_indirect_port(input logic [7:0] a);
    is_indirect_port = (a == ADDR_INDIRECT_ZERO) || (a == ADDR_INDIRECT_ONE);
  endfunction : is_indirect_port

  function automatic logic [7:0] bit_update(input logic [7:0] v, input logic [2:0] b, input logic setv);
    logic [7:0] m;
    m = 8'h01 << b;
    bit_update = setv ? (v | m) : (v & ~m);
  endfunction : bit_update

  // The dummy cycle swallows the request slot; the core must hold off
  assign accept = REQ_VALID && (flow_q == ST_RUN);

  always_comb begin
    eff_indirect = is_indirect_port(REQ_ADDR);
    eff_bank = 1'b0;
    eff_addr = REQ_ADDR;
    if (REQ_ADDR == ADDR_INDIRECT_ZERO) begin
      eff_addr = ptr0_q;
      eff_bank = 1'b0;
    end else if (REQ_ADDR == ADDR_INDIRECT_ONE) begin
      eff_addr = ptr1_q;
      eff_bank = bank_q;
    end
    eff_null = eff_indirect && is_indirect_port(eff_addr);
  end

  always_comb begin
    gp_hit = 1'b0;
    gp_idx = '0;
    if (!eff_bank && eff_addr >= GP_BASE_BANK0) begin
      gp_hit = 1'b1;
      gp_idx = GP_IDX_W'(eff_addr - GP_BASE_BANK0);
    end else if (eff_bank && eff_addr >= GP_BASE_BANK1) begin
      gp_hit = 1'b1;
      gp_idx = GP_IDX_W'(GP_BANK0_SIZE + int'(eff_addr - GP_BASE_BANK1));
    end
  end

  // Bank 1 60-7F and unclaimed bank 0 locations hold nothing
  assign sp_unused = !gp_hit && !PERIPH_HIT && (eff_addr > ADDR_PC_LOW);

  always_comb begin
    rd_value = READ_ZERO;
    if (eff_null) begin
      rd_value = READ_ZERO;
    end else if (gp_hit) begin
      rd_value = gp_mem_q[gp_idx];
    end else begin
      case (eff_addr)
        ADDR_POINTER_ZERO: rd_value = ptr0_q;
        ADDR_POINTER_ONE: rd_value = ptr1_q;
        ADDR_BANK_SELECT: rd_value = {7'h00, bank_q};
        ADDR_ACCUMULATOR: rd_value = acc_q;
        ADDR_PC_LOW: rd_value = PC_IN[7:0];
        default: rd_value = sp_unused ? READ_ZERO : PERIPH_RDATA;
      endcase
    end
  end

  always_comb begin
    wr_value = REQ_WDATA;
    do_write = 1'b0;
    case (REQ_OP)
      OP_WRITE: do_write = 1'b1;
      OP_BIT_SET: begin
        wr_value = bit_update(rd_value, REQ_BIT, 1'b1);
        do_write = 1'b1;
      end
      OP_BIT_CLR: begin
        wr_value = bit_update(rd_value, REQ_BIT, 1'b0);
        do_write = 1'b1;
      end
      default: do_write = 1'b0;
    endcase
    if (!accept || eff_null) begin
      do_write = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (do_write && gp_hit) begin
      gp_mem_q[gp_idx] <= wr_value;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      acc_q <= RESET_BYTE;
    end else if (accept && REQ_OP == OP_ALU_ACC) begin
      acc_q <= ALU_RESULT;
    end else if (do_write && !gp_hit && eff_addr == ADDR_ACCUMULATOR) begin
      acc_q <= wr_value;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ptr0_q <= RESET_BYTE;
      ptr1_q <= RESET_BYTE;
    end else if (do_write && !gp_hit) begin
      if (eff_addr == ADDR_POINTER_ZERO) begin
        ptr0_q <= wr_value;
      end
      if (eff_addr == ADDR_POINTER_ONE) begin
        ptr1_q <= wr_value;
      end
    end
  end

  // Reset is asynchronous, so a sleeping watchdog reset is seen as a
  // synchronous pulse from the core and leaves the bank untouched
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      bank_q <= RESET_BANK;
    end else if (WDT_SLEEP_RESET) begin
      bank_q <= bank_q;
    end else if (do_write && !gp_hit && eff_addr == ADDR_BANK_SELECT) begin
      bank_q <= wr_value[BANK_BIT_POS];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      flow_q <= ST_RUN;
      jump_valid_q <= 1'b0;
      jump_target_q <= '0;
    end else begin
      jump_valid_q <= 1'b0;
      case (flow_q)
        ST_RUN: begin
          if (do_write && !gp_hit && eff_addr == ADDR_PC_LOW && !WDT_SLEEP_RESET) begin
            jump_valid_q <= 1'b1;
            jump_target_q <= {PC_IN[PC_WIDTH-1:8], wr_value};
            flow_q <= ST_DUMMY;
          end
        end
        ST_DUMMY: flow_q <= ST_RUN;
        default: flow_q <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      resp_valid_q <= 1'b0;
      resp_rdata_q <= RESET_BYTE;
    end else begin
      resp_valid_q <= accept;
      if (accept) begin
        resp_rdata_q <= rd_value;
      end
    end
  end

  // Peripheral window: only the nonvolatile control needs bank 1
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      periph_we_q <= 1'b0;
      periph_addr_q <= RESET_BYTE;
      periph_bank_q <= 1'b0;
      periph_wdata_q <= RESET_BYTE;
    end else begin
      periph_we_q <= do_write && !gp_hit && PERIPH_HIT && !PERIPH_READ_ONLY;
      periph_addr_q <= eff_addr;
      periph_bank_q <= eff_bank;
      periph_wdata_q <= wr_value;
    end
  end

  assign RESP_VALID = resp_valid_q;
  assign RESP_RDATA = resp_rdata_q;
  assign ACC_OUT = acc_q;
  assign POINTER_ZERO_OUT = ptr0_q;
  assign POINTER_ONE_OUT = ptr1_q;
  assign BANK_SELECT_BIT = bank_q;
  assign JUMP_VALID = jump_valid_q;
  assign JUMP_TARGET = jump_target_q;
  // One-hot state: the dummy bit is itself a flop, so the output needs no decode
  assign DUMMY_CYCLE = flow_q[1];
  assign PERIPH_WE = periph_we_q;
  assign PERIPH_ADDR = periph_addr_q;
  assign PERIPH_BANK = periph_bank_q;
  assign PERIPH_WDATA = periph_wdata_q;

endmodule : banked_dmem
`default_nettype wire

// File: verilog/dmem_pkg.sv
`default_nettype none
package dmem_pkg;
  localparam logic [7:0] ADDR_INDIRECT_ZERO = 8'h00;
  localparam logic [7:0] ADDR_POINTER_ZERO = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_ONE = 8'h02;
  localparam logic [7:0] ADDR_POINTER_ONE = 8'h03;
  localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'h05;
  localparam logic [7:0] ADDR_PC_LOW = 8'h06;
  localparam logic [7:0] ADDR_NV_CONTROL = 8'h40;
  localparam logic [7:0] GP_BASE_BANK0 = 8'h60;
  localparam logic [7:0] GP_BASE_BANK1 = 8'h80;
  localparam logic [7:0] SP_END_BANK0 = 8'h5f;
  localparam int GP_BANK0_SIZE = 160;
  localparam int GP_TOTAL_SIZE = 288;
  localparam int BANK_BIT_POS = 0;
  localparam logic RESET_BANK = 1'b0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int DUMMY_CYCLES = 1;
  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_WRITE = 3'b001,
    OP_BIT_SET = 3'b010,
    OP_BIT_CLR = 3'b011,
    OP_ALU_ACC = 3'b100
  } mem_op_t;
endpackage : dmem_pkg
`default_nettype wire

// File: verif/dmem_chk.sv
`default_nettype none
module dmem_chk
  import dmem_pkg::*;
#(
  parameter int PC_WIDTH = 12
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic WDT_SLEEP_RESET,
  input wire logic REQ_VALID,
  input wire logic [2:0] REQ_OP,
  input wire logic [7:0] REQ_ADDR,
  input wire logic [7:0] REQ_WDATA,
  input wire logic [7:0] ALU_RESULT,
  input wire logic [PC_WIDTH-1:0] PC_IN,
  input wire logic PERIPH_HIT,
  input wire logic RESP_VALID,
  input wire logic [7:0] RESP_RDATA,
  input wire logic [7:0] ACC_OUT,
  input wire logic [7:0] POINTER_ZERO_OUT,
  input wire logic BANK_SELECT_BIT,
  input wire logic JUMP_VALID,
  input wire logic [PC_WIDTH-1:0] JUMP_TARGET,
  input wire logic DUMMY_CYCLE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  logic take, wr, rd, jmp;
  assign take = REQ_VALID && !DUMMY_CYCLE;
  assign wr = take && REQ_OP == OP_WRITE;
  assign rd = take && REQ_OP == OP_READ;
  // A sleeping watchdog reset blocks the jump as well as the bank write
  assign jmp = wr && REQ_ADDR == ADDR_PC_LOW && !WDT_SLEEP_RESET;
  a_resp_next: assert property (take |=> RESP_VALID) else $error("no response");
  a_jump_dummy: assert property (jmp |=> JUMP_VALID && DUMMY_CYCLE ##1 !DUMMY_CYCLE)
    else $error("jump without one dummy cycle");
  a_jump_page: assert property (jmp |=> JUMP_TARGET == {$past(PC_IN[PC_WIDTH-1:8]), $past(REQ_WDATA)})
    else $error("jump left the page");
  a_bank_write: assert property (wr && REQ_ADDR == ADDR_BANK_SELECT && !WDT_SLEEP_RESET
    |=> BANK_SELECT_BIT == $past(REQ_WDATA[0])) else $error("bank bit not written");
  a_bank_hold: assert property (WDT_SLEEP_RESET |=> $stable(BANK_SELECT_BIT))
    else $error("bank moved under watchdog reset");
  a_bank_read: assert property (rd && REQ_ADDR == ADDR_BANK_SELECT
    |=> RESP_RDATA == {7'h00, BANK_SELECT_BIT}) else $error("bank readback wrong");
  a_ptr_write: assert property (wr && REQ_ADDR == ADDR_POINTER_ZERO
    |=> POINTER_ZERO_OUT == $past(REQ_WDATA)) else $error("pointer not written");
  a_acc_load: assert property (take && REQ_OP == OP_ALU_ACC |=> ACC_OUT == $past(ALU_RESULT))
    else $error("accumulator not loaded");
  a_unused_zero: assert property (rd && REQ_ADDR inside {[8'h07:8'h5f]} && !PERIPH_HIT
    |=> RESP_RDATA == READ_ZERO) else $error("unused location not zero");
endmodule : dmem_chk
bind banked_dmem dmem_chk #(.PC_WIDTH(PC_WIDTH)) u_dmem_chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .WDT_SLEEP_RESET(WDT_SLEEP_RESET), .REQ_VALID(REQ_VALID),
  .REQ_OP(REQ_OP), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .ALU_RESULT(ALU_RESULT), .PC_IN(PC_IN),
  .PERIPH_HIT(PERIPH_HIT), .RESP_VALID(RESP_VALID), .RESP_RDATA(RESP_RDATA), .ACC_OUT(ACC_OUT),
  .POINTER_ZERO_OUT(POINTER_ZERO_OUT), .BANK_SELECT_BIT(BANK_SELECT_BIT), .JUMP_VALID(JUMP_VALID),
  .JUMP_TARGET(JUMP_TARGET), .DUMMY_CYCLE(DUMMY_CYCLE));
`default_nettype wire

// File: verif/periph_model.sv
`default_nettype none
module periph_model (
  input wire logic [7:0] req_addr,
  input wire logic [7:0] ptr_zero,
  input wire logic [7:0] ptr_one,
  input wire logic bank,
  output logic hit,
  output logic ro,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] ea;
  always_comb begin
    ea = {1'b0, req_addr};
    if (req_addr == 8'h00) ea = {1'b0, ptr_zero};
    if (req_addr == 8'h02) ea = {bank, ptr_one};
    hit = ea == 9'h140 || ea[7:0] == 8'h0a;
    ro = ea[7:0] == 8'h0a;
    // Garbage when not selected, so a decode that ignores hit shows up
    rdata = hit ? (ro ? 8'h3c : 8'h5a) : ea[7:0] ^ 8'ha5;
  end
endmodule : periph_model
`default_nettype wire

// File: verif/banked_dmem_tb.sv
`default_nettype none
module banked_dmem_tb
  import dmem_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK_SYS, RST_N, WDT_SLEEP_RESET, REQ_VALID, hit, ro, RESP_VALID, bank;
  logic JUMP_VALID, DUMMY_CYCLE, PERIPH_WE, PERIPH_BANK;
  logic [2:0] REQ_OP, REQ_BIT;
  logic [7:0] REQ_ADDR, REQ_WDATA, ALU_RESULT, prd, RESP_RDATA, ACC_OUT, p0, p1, PERIPH_ADDR, PERIPH_WDATA;
  logic [11:0] PC_IN, JUMP_TARGET;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  banked_dmem u_banked_dmem (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .WDT_SLEEP_RESET(WDT_SLEEP_RESET),
    .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_BIT(REQ_BIT),
    .ALU_RESULT(ALU_RESULT), .PC_IN(PC_IN), .PERIPH_RDATA(prd), .PERIPH_HIT(hit), .PERIPH_READ_ONLY(ro),
    .RESP_VALID(RESP_VALID), .RESP_RDATA(RESP_RDATA), .ACC_OUT(ACC_OUT), .POINTER_ZERO_OUT(p0),
    .POINTER_ONE_OUT(p1), .BANK_SELECT_BIT(bank), .JUMP_VALID(JUMP_VALID), .JUMP_TARGET(JUMP_TARGET),
    .DUMMY_CYCLE(DUMMY_CYCLE), .PERIPH_WE(PERIPH_WE), .PERIPH_ADDR(PERIPH_ADDR), .PERIPH_BANK(PERIPH_BANK),
    .PERIPH_WDATA(PERIPH_WDATA));
  periph_model u_periph_model (.req_addr(REQ_ADDR), .ptr_zero(p0), .ptr_one(p1), .bank(bank), .hit(hit),
    .ro(ro), .rdata(prd));
  task automatic stop_test();
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Request stays up on return so back-to-back calls need no idle edge
  task automatic op(input logic [2:0] o, input logic [7:0] a, input logic [7:0] d, input logic [2:0] b);
    REQ_OP = o;
    REQ_ADDR = a;
    REQ_WDATA = d;
    REQ_BIT = b;
    REQ_VALID = 1'b1;
    @(posedge CLK_SYS);
    #1;
  endtask : op
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(OP_WRITE, a, d, 3'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(OP_READ, a, 8'h00, 3'h0);
    chk({RESP_VALID, RESP_RDATA}, {1'b1, e}, "read");
  endtask : rd
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    {RST_N, WDT_SLEEP_RESET, REQ_VALID, REQ_OP, REQ_BIT} = '0;
    {REQ_ADDR, REQ_WDATA} = '0;
    PC_IN = 12'h3c5;
    ALU_RESULT = 8'h77;
    repeat (20) @(posedge CLK_SYS);
    #1 RST_N = 1'b1;
    rd(ADDR_BANK_SELECT, 8'h00);
    wr(8'h60, 8'ha5);
    wr(8'hff, 8'h5c);
    wr(8'h80, 8'h11);
    rd(8'h60, 8'ha5);
    rd(8'hff, 8'h5c);
    wr(ADDR_BANK_SELECT, 8'hff);
    rd(ADDR_BANK_SELECT, 8'h01);
    wr(ADDR_POINTER_ONE, 8'h80);
    wr(ADDR_INDIRECT_ONE, 8'h3c);
    rd(8'h80, 8'h11);
    rd(ADDR_INDIRECT_ONE, 8'h3c);
    rd(ADDR_POINTER_ONE, 8'h80);
    wr(ADDR_POINTER_ZERO, 8'h80);
    rd(ADDR_INDIRECT_ZERO, 8'h11);
    wr(ADDR_POINTER_ONE, 8'h60);
    wr(ADDR_INDIRECT_ONE, 8'hee);
    rd(ADDR_INDIRECT_ONE, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    wr(ADDR_POINTER_ONE, ADDR_INDIRECT_ZERO);
    wr(ADDR_INDIRECT_ONE, 8'h99);
    rd(ADDR_INDIRECT_ONE, 8'h00);
    wr(ADDR_POINTER_ONE, 8'h80);
    rd(ADDR_INDIRECT_ONE, 8'h3c);
    wr(ADDR_POINTER_ONE, ADDR_NV_CONTROL);
    wr(ADDR_INDIRECT_ONE, 8'h0b);
    chk({PERIPH_WE, PERIPH_BANK, PERIPH_ADDR, PERIPH_WDATA}, {2'b11, ADDR_NV_CONTROL, 8'h0b}, "periph");
    rd(ADDR_INDIRECT_ONE, 8'h5a);
    rd(ADDR_NV_CONTROL, 8'h00);
    wr(8'h0a, 8'h01);
    chk(PERIPH_WE, 1'b0, "protected");
    rd(8'h0a, 8'h3c);
    wr(8'h61, 8'h0f);
    op(OP_BIT_SET, 8'h61, 8'h00, 3'h7);
    op(OP_BIT_CLR, 8'h61, 8'h00, 3'h0);
    rd(8'h61, 8'h8e);
    op(OP_ALU_ACC, 8'h00, 8'h00, 3'h0);
    chk(ACC_OUT, 8'h77, "acc");
    rd(ADDR_ACCUMULATOR, 8'h77);
    WDT_SLEEP_RESET = 1'b1;
    wr(ADDR_BANK_SELECT, 8'h00);
    WDT_SLEEP_RESET = 1'b0;
    rd(ADDR_BANK_SELECT, 8'h01);
    wr(ADDR_PC_LOW, 8'h12);
    chk({JUMP_VALID, DUMMY_CYCLE, JUMP_TARGET}, {2'b11, 12'h312}, "jump");
    op(OP_READ, 8'h60, 8'h00, 3'h0);
    chk(RESP_VALID, 1'b0, "dummy");
    rd(8'h60, 8'ha5);
    REQ_VALID = 1'b0;
    RST_N = 1'b0;
    @(posedge CLK_SYS);
    #1 RST_N = 1'b1;
    rd(ADDR_BANK_SELECT, 8'h00);
    stop_test();
  end
endmodule : banked_dmem_tb
`default_nettype wire
